// ===== hdl/gpio_params.svh
// Constants for the parallel I/O port block: register map, port layout and reset values.
// Behaviour
// - Writing an input pin only loads its latch
// - Reading an input pin returns sampled pin level
// - Input pin read-modify-write sources the pin level
// - Output pin write updates latch and drives pin
// - Reading an output pin returns its latch
// - Output pin read-modify-write sources the latch
// - Every pin sampled each clock regardless of direction
// - Ports 2,3,4,6,7,8 offer per-bit open drain
// - TTL thresholds by default, CMOS selectable everywhere
// - One threshold bit per byte of each port
// - Direction and drive mode independent of threshold
// - Port 3 has fifteen lines, line 14 absent
// - Port 5 is sixteen input-only lines
// - Ports 0 and 1 split into addressable bytes
// - Ports 4,6,7,8 eight lines, port 2 sixteen
// - Alternate output drives latch AND alternate data
// - After reset every pin is input, undriven
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH

`define NUM_PORTS 11
`define LANE_W 16
`define ADDR_W 9
`define DATA_W 32

// Port lane indices.
`define IDX_P0L 4'h0
`define IDX_P0H 4'h1
`define IDX_P1L 4'h2
`define IDX_P1H 4'h3
`define IDX_P2 4'h4
`define IDX_P3 4'h5
`define IDX_P4 4'h6
`define IDX_P5 4'h7
`define IDX_P6 4'h8
`define IDX_P7 4'h9
`define IDX_P8 4'hA

// Address layout: region in bits 8..6, lane index in bits 5..2.
`define REGION_MSB 8
`define REGION_LSB 6
`define INDEX_MSB 5
`define INDEX_LSB 2
`define REGION_DATA 3'h0
`define REGION_DIR 3'h1
`define REGION_OD 3'h2
`define REGION_THR 3'h3
`define REGION_SET 3'h4
`define REGION_CLR 3'h5
`define REGION_TGL 3'h6
`define REGION_PIN 3'h7
`define THR_INDEX 4'h0
`define EXT_THR_INDEX 4'h1

// Line masks.
`define MASK_BYTE 16'h00FF
`define MASK_WORD 16'hFFFF
`define MASK_P3 16'hBFFF
`define MASK_NONE 16'h0000

// Threshold register widths.
`define THR_W 8
`define EXT_THR_W 6

// Reset values.
`define RESET_LATCH 16'h0000
`define RESET_DIR 16'h0000
`define RESET_OD 16'h0000
`define RESET_THR 8'h00
`define RESET_EXT_THR 6'h00
`define RESET_RDATA 32'h0000_0000

`endif

// ===== hdl/gpio_pkg.sv
// Types shared by the parallel I/O port block.
`include "gpio_params.svh"
package gpio_pkg;
   typedef logic [`LANE_W-1:0] port_word_t;
   typedef logic [`NUM_PORTS-1:0][`LANE_W-1:0] port_vec_t;
   typedef logic [`ADDR_W-1:0] bus_addr_t;
   typedef logic [`DATA_W-1:0] bus_data_t;
   typedef logic [3:0] lane_idx_t;
   typedef logic [2:0] region_t;
   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ANSWER = 1'b1
   } bus_state_t;
endpackage : gpio_pkg

// ===== hdl/parallel_io_ports.sv
// Parallel I/O ports with latches, direction, open drain and threshold control on Avalon-MM.
`timescale 1ns/100ps
`include "gpio_params.svh"
module parallel_io_ports (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset_n,
   // Avalon-MM slave.
   input wire gpio_pkg::bus_addr_t address,
   input wire logic read,
   input wire logic write,
   input wire gpio_pkg::bus_data_t writedata,
   input wire logic [3:0] byteenable,
   output gpio_pkg::bus_data_t readdata,
   output logic waitrequest,
   // Pads, one 16-bit lane per port or port half.
   input wire gpio_pkg::port_vec_t pad_in,
   output gpio_pkg::port_vec_t pad_out,
   output gpio_pkg::port_vec_t pad_oe,
   // Alternate output functions.
   input wire gpio_pkg::port_vec_t alt_out_en,
   input wire gpio_pkg::port_vec_t alt_out_data,
   // Input threshold selects to the pad cells, 1 selects CMOS.
   output logic [`THR_W-1:0] threshold_select_reg,
   output logic [`EXT_THR_W-1:0] ext_threshold_select_reg
);
   import gpio_pkg::*;

   // Lines that exist in each lane; unused upper bytes and the missing port 3 line stay zero.
   function automatic port_word_t impl_mask(input lane_idx_t idx);
      case (idx)
         `IDX_P0L: impl_mask = `MASK_BYTE;
         `IDX_P0H: impl_mask = `MASK_BYTE;
         `IDX_P1L: impl_mask = `MASK_BYTE;
         `IDX_P1H: impl_mask = `MASK_BYTE;
         `IDX_P2: impl_mask = `MASK_WORD;
         `IDX_P3: impl_mask = `MASK_P3;
         `IDX_P4: impl_mask = `MASK_BYTE;
         `IDX_P5: impl_mask = `MASK_WORD;
         `IDX_P6: impl_mask = `MASK_BYTE;
         `IDX_P7: impl_mask = `MASK_BYTE;
         `IDX_P8: impl_mask = `MASK_BYTE;
         default: impl_mask = `MASK_NONE;
      endcase
   endfunction : impl_mask

   // Lines that have an output driver; port 5 listens only.
   function automatic port_word_t out_mask(input lane_idx_t idx);
      case (idx)
         `IDX_P5: out_mask = `MASK_NONE;
         default: out_mask = impl_mask(idx);
      endcase
   endfunction : out_mask

   // Lines that offer the open drain option.
   function automatic port_word_t od_mask(input lane_idx_t idx);
      case (idx)
         `IDX_P2: od_mask = impl_mask(idx);
         `IDX_P3: od_mask = impl_mask(idx);
         `IDX_P4: od_mask = impl_mask(idx);
         `IDX_P6: od_mask = impl_mask(idx);
         `IDX_P7: od_mask = impl_mask(idx);
         `IDX_P8: od_mask = impl_mask(idx);
         default: od_mask = `MASK_NONE;
      endcase
   endfunction : od_mask

   // Byte-enabled merge of a 16-bit write into an old value.
   function automatic port_word_t merge16(input port_word_t old, input port_word_t wdata, input logic [1:0] be);
      merge16 = {be[1] ? wdata[15:8] : old[15:8], be[0] ? wdata[7:0] : old[7:0]};
   endfunction : merge16

   // Value a port read shows: the latch where the line drives, the pin where it listens.
   function automatic port_word_t port_view(input port_word_t dir_w, input port_word_t latch_w, input port_word_t pin_w);
      port_view = (dir_w & latch_w) | (~dir_w & pin_w);
   endfunction : port_view

   // Bit operation of a read-modify-write region on its source word.
   function automatic port_word_t rmw_apply(input region_t reg_sel, input port_word_t src, input port_word_t op);
      case (reg_sel)
         `REGION_SET: rmw_apply = src | op;
         `REGION_CLR: rmw_apply = src & ~op;
         `REGION_TGL: rmw_apply = src ^ op;
         default: rmw_apply = src;
      endcase
   endfunction : rmw_apply

   port_vec_t latch;
   port_vec_t dir;
   port_vec_t od;
   port_vec_t pin_sample;
   bus_state_t state;

   // Bus decode.
   wire region_t region = address[`REGION_MSB:`REGION_LSB];
   wire lane_idx_t idx = address[`INDEX_MSB:`INDEX_LSB];
   wire idx_ok = (idx <= `IDX_P8);
   wire lane_idx_t sel_idx = idx_ok ? idx : `IDX_P0L;
   wire take = (state == BUS_IDLE) && (read || write);
   wire commit = (state == BUS_ANSWER) && write;
   wire [1:0] be16 = byteenable[1:0];
   wire port_word_t wd16 = writedata[15:0];
   wire port_word_t op16 = wd16 & {{8{be16[1]}}, {8{be16[0]}}};
   wire port_word_t sel_mask = impl_mask(sel_idx);

   // Region decode.
   wire is_data = (region == `REGION_DATA);
   wire is_dir = (region == `REGION_DIR);
   wire is_od = (region == `REGION_OD);
   wire is_thr = (region == `REGION_THR);
   wire is_set = (region == `REGION_SET);
   wire is_clr = (region == `REGION_CLR);
   wire is_tgl = (region == `REGION_TGL);
   wire is_pin = (region == `REGION_PIN);
   wire is_rmw = is_set || is_clr || is_tgl;

   // Port reads: driven lines show the latch, others the sampled pin.
   wire port_word_t sel_port_view = port_view(dir[sel_idx], latch[sel_idx], pin_sample[sel_idx]) & sel_mask;
   wire port_word_t rd_dir = dir[sel_idx];
   wire port_word_t rd_od = od[sel_idx];
   wire port_word_t rd_pin = pin_sample[sel_idx] & sel_mask;

   // Read-modify-write regions read back as zero; they exist only as write strobes.
   wire port_word_t rd16 =
      !idx_ok ? `MASK_NONE :
      is_data ? sel_port_view :
      is_dir ? rd_dir :
      is_od ? rd_od :
      is_pin ? rd_pin :
      `MASK_NONE;

   wire bus_data_t rd_thr =
      (idx == `THR_INDEX) ? {{(`DATA_W-`THR_W){1'b0}}, threshold_select_reg} :
      (idx == `EXT_THR_INDEX) ? {{(`DATA_W-`EXT_THR_W){1'b0}}, ext_threshold_select_reg} :
      `RESET_RDATA;

   wire bus_data_t next_readdata = is_thr ? rd_thr : {16'h0000, rd16};

   // One wait cycle per access: the request is taken in IDLE, answered in ANSWER.
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state <= BUS_IDLE;
         waitrequest <= 1'b1;
         readdata <= `RESET_RDATA;
      end else begin
         case (state)
            BUS_IDLE: begin
               if (take) begin
                  state <= BUS_ANSWER;
                  waitrequest <= 1'b0;
                  readdata <= read ? next_readdata : `RESET_RDATA;
               end
            end
            BUS_ANSWER: begin
               state <= BUS_IDLE;
               waitrequest <= 1'b1;
            end
            default: begin
               state <= BUS_IDLE;
               waitrequest <= 1'b1;
            end
         endcase
      end
   end

   // Threshold selects, one bit per byte of each port; they never touch direction or drive mode.
   // First select register, a set bit picks CMOS levels:
   // bit 0 port 0 low byte, bit 1 port 0 high byte,
   // bit 2 port 1 low byte, bit 3 port 1 high byte,
   // bit 4 port 2 low byte, bit 5 port 2 high byte,
   // bit 6 port 3 low byte, bit 7 port 3 high byte.
   // Second select register:
   // bit 0 port 4, bit 1 port 5 low byte, bit 2 port 5 high byte,
   // bit 3 port 6, bit 4 port 7, bit 5 port 8.
   // Both are plain selects to the pad cells; the sampled level stays digital here.
   wire thr_hit = commit && is_thr && (idx == `THR_INDEX) && be16[0];
   wire ext_thr_hit = commit && is_thr && (idx == `EXT_THR_INDEX) && be16[0];

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         threshold_select_reg <= `RESET_THR;
         ext_threshold_select_reg <= `RESET_EXT_THR;
      end else begin
         if (thr_hit) begin
            threshold_select_reg <= writedata[`THR_W-1:0];
         end
         if (ext_thr_hit) begin
            ext_threshold_select_reg <= writedata[`EXT_THR_W-1:0];
         end
      end
   end

   // Per-lane latch, direction, drive mode and pad logic.
   genvar g;
   generate
      for (g = 0; g < `NUM_PORTS; g = g + 1) begin : lane
         localparam lane_idx_t LIDX = lane_idx_t'(g);
         wire port_word_t omask = out_mask(LIDX);
         wire port_word_t dmask = od_mask(LIDX);
         wire hit = commit && (idx == LIDX);
         // Read-modify-write source: latch for outputs, pin for inputs.
         wire port_word_t rmw_src = port_view(dir[g], latch[g], pin_sample[g]);
         // Data writes load the latch whatever the direction; only the enable decides the pin.
         wire port_word_t data_val = merge16(latch[g], wd16, be16) & omask;
         wire port_word_t rmw_val = rmw_apply(region, rmw_src, op16) & omask;
         wire data_hit = hit && is_data;
         wire rmw_hit = hit && is_rmw;
         wire dir_hit = hit && is_dir;
         wire od_hit = hit && is_od;
         wire port_word_t next_latch =
            data_hit ? data_val :
            rmw_hit ? rmw_val :
            latch[g];
         wire port_word_t next_dir = dir_hit ? merge16(dir[g], wd16, be16) & omask : dir[g];
         wire port_word_t next_od = od_hit ? merge16(od[g], wd16, be16) & dmask : od[g];
         // Alternate output data is ANDed with the latch where enabled.
         wire port_word_t drive_val = latch[g] & (alt_out_data[g] | ~alt_out_en[g]);
         // Open drain lines only ever pull low; push-pull lines drive both levels.
         wire port_word_t next_oe = dir[g] & (~od[g] | ~drive_val) & omask;
         wire port_word_t next_out = drive_val & ~od[g] & omask;
         // Absent lines sample as zero so no read can show a floating pad.
         wire port_word_t next_sample = pad_in[g] & impl_mask(LIDX);

         // Control state: latch, direction and drive mode.
         always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               latch[g] <= `RESET_LATCH;
               dir[g] <= `RESET_DIR;
               od[g] <= `RESET_OD;
            end else begin
               latch[g] <= next_latch;
               dir[g] <= next_dir;
               od[g] <= next_od;
            end
         end

         // Pad drive is registered so a decode change never glitches a pin.
         always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               pad_oe[g] <= `MASK_NONE;
               pad_out[g] <= `MASK_NONE;
            end else begin
               pad_oe[g] <= next_oe;
               pad_out[g] <= next_out;
            end
         end

         // Pins are sampled on every clock, whatever their direction.
         always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               pin_sample[g] <= `MASK_NONE;
            end else begin
               pin_sample[g] <= next_sample;
            end
         end
      end
   endgenerate
endmodule : parallel_io_ports

// ===== dv/parallel_io_ports_asserts.sv
// Concurrent checks on the ports of the parallel I/O port block.
`timescale 1ns/100ps
module parallel_io_ports_asserts (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic reset_n,
   // Register bus.
   input wire gpio_pkg::bus_addr_t address,
   input wire logic read,
   input wire logic write,
   input wire gpio_pkg::bus_data_t writedata,
   input wire logic [3:0] byteenable,
   input wire gpio_pkg::bus_data_t readdata,
   input wire logic waitrequest,
   // Pads and threshold selects.
   input wire gpio_pkg::port_vec_t pad_in,
   input wire gpio_pkg::port_vec_t pad_oe,
   input wire logic [7:0] threshold_select_reg
);
   import gpio_pkg::*;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   sequence p5_read_s;
      $rose(read) && address == 9'h01C ##1 !waitrequest;
   endsequence
   sequence thr_write_s;
      $rose(write) && address == 9'h0C0 && byteenable[0] ##1 !waitrequest;
   endsequence
   wait_once_a: assert property (!waitrequest |=> waitrequest)
      else $error("wait low for more than one cycle");
   req_answer_a: assert property ($rose(read | write) |=> !waitrequest)
      else $error("request not answered in the next cycle");
   p5_undriven_a: assert property (pad_oe[7] == 16'h0000)
      else $error("input only port driven");
   p3_gap_a: assert property (!pad_oe[5][14])
      else $error("absent port 3 line driven");
   byte_upper_a: assert property ((pad_oe[0][15:8] | pad_oe[6][15:8] | pad_oe[10][15:8]) == 8'h00)
      else $error("absent upper byte driven");
   reset_input_a: assert property ($rose(reset_n) |-> pad_oe == '0)
      else $error("driver enabled after reset");
   pin_read_a: assert property (p5_read_s |-> readdata[15:0] == $past(pad_in[7], 2))
      else $error("input read does not show pin level");
   thr_write_a: assert property (thr_write_s |=> threshold_select_reg == $past(writedata[7:0]))
      else $error("threshold select not updated");
endmodule : parallel_io_ports_asserts
bind parallel_io_ports parallel_io_ports_asserts chk_i (.clk_sys, .reset_n, .address, .read, .write, .writedata,
   .byteenable, .readdata, .waitrequest, .pad_in, .pad_oe, .threshold_select_reg);

// ===== dv/pin_board_model.sv
// Board-side model of the pins seen by the parallel I/O port block.
`timescale 1ns/100ps
module pin_board_model (
   // Block side.
   input wire gpio_pkg::port_vec_t pad_out,
   input wire gpio_pkg::port_vec_t pad_oe,
   // External drivers.
   input wire gpio_pkg::port_vec_t ext_val,
   // Levels at the pins.
   output gpio_pkg::port_vec_t pad_in
);
   import gpio_pkg::*;
   // A driven pin shows the block's level, any other pin the external level.
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_val);
endmodule : pin_board_model

// ===== dv/test_parallel_io_ports.sv
// Self-checking testbench for the parallel I/O port block.
`timescale 1ns/100ps
module test_parallel_io_ports;
   import gpio_pkg::*;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [3:0] byteenable = 4'hF;
   bus_addr_t address = '0;
   bus_data_t writedata = '0;
   bus_data_t readdata;
   logic waitrequest;
   port_vec_t pad_in, pad_out, pad_oe;
   port_vec_t ext_val = '0;
   port_vec_t alt_out_en = '0;
   port_vec_t alt_out_data = '0;
   logic [7:0] threshold_select_reg;
   logic [5:0] ext_threshold_select_reg;
   int error_cnt = 0;
   int num_checks = 0;
   always #2 clk_sys = ~clk_sys;
   parallel_io_ports uut (.clk_sys, .reset_n, .address, .read, .write, .writedata, .byteenable, .readdata,
      .waitrequest, .pad_in, .pad_out, .pad_oe, .alt_out_en, .alt_out_data, .threshold_select_reg,
      .ext_threshold_select_reg);
   pin_board_model board (.pad_out, .pad_oe, .ext_val, .pad_in);
   task automatic test_done;
      if (error_cnt == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : test_done
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      num_checks++;
      if (s !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask : chk
   task automatic bus_xfer(input logic rd, input bus_addr_t a, input bus_data_t d, output bus_data_t q);
      @(posedge clk_sys);
      address <= a;
      writedata <= d;
      read <= rd;
      write <= !rd;
      do @(posedge clk_sys); while (waitrequest !== 1'b0);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk_sys);
   endtask : bus_xfer
   // The whole sequence needs well under a thousand cycles.
   initial begin
      #20000;
      error_cnt++;
      test_done;
   end
   initial begin
      logic [15:0] m, pm, ev, lat, d, a;
      bus_data_t q;
      bit od;
      void'($urandom(35));
      repeat (4) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(negedge clk_sys);
      chk("reset", 32'h0, {|pad_oe, ext_threshold_select_reg, threshold_select_reg});
      d = $urandom;
      bus_xfer(1'b0, 9'h0C0, {16'h0, d}, q);
      bus_xfer(1'b0, 9'h0C4, {16'h0, d}, q);
      chk("thr", {d[5:0], d[7:0]}, {ext_threshold_select_reg, threshold_select_reg});
      for (int i = 0; i < 11; i++) begin
         m = (i == 4) ? 16'hFFFF : (i == 5) ? 16'hBFFF : (i == 7) ? 16'h0000 : 16'h00FF;
         pm = (i == 7) ? 16'hFFFF : m;
         ev = $urandom;
         d = $urandom;
         @(posedge clk_sys);
         ext_val[i] <= ev;
         bus_xfer(1'b0, 9'(i * 4), {16'h0, d}, q);
         @(negedge clk_sys);
         chk("oe_in", 32'h0, pad_oe[i]);
         bus_xfer(1'b1, 9'(i * 4), 32'h0, q);
         chk("rd_in", ev & pm, q);
         d = $urandom;
         lat = (ev | d) & m;
         bus_xfer(1'b0, 9'h100 + 9'(i * 4), {16'h0, d}, q);
         bus_xfer(1'b0, 9'h040 + 9'(i * 4), 32'hFFFF, q);
         bus_xfer(1'b1, 9'(i * 4), 32'h0, q);
         chk("rd_out", lat | (ev & pm & ~m), q);
         @(negedge clk_sys);
         chk("oe_out", m, pad_oe[i]);
         chk("out", lat, pad_out[i]);
         d = $urandom;
         lat = (lat ^ d) & m;
         bus_xfer(1'b0, 9'h180 + 9'(i * 4), {16'h0, d}, q);
         bus_xfer(1'b1, 9'(i * 4), 32'h0, q);
         chk("rmw_out", lat | (ev & pm & ~m), q);
         a = $urandom;
         @(posedge clk_sys);
         alt_out_en[i] <= 16'hFFFF;
         alt_out_data[i] <= a;
         repeat (2) @(posedge clk_sys);
         @(negedge clk_sys);
         chk("alt", lat & a, pad_out[i]);
         @(posedge clk_sys);
         alt_out_en[i] <= 16'h0000;
         od = i inside {4, 5, 6, 8, 9, 10};
         bus_xfer(1'b0, 9'h080 + 9'(i * 4), 32'hFFFF, q);
         @(negedge clk_sys);
         chk("od_oe", od ? m & ~lat : m, pad_oe[i]);
         chk("od_out", od ? 16'h0 : lat, pad_out[i]);
      end
      bus_xfer(1'b1, 9'h02C, 32'h0, q);
      chk("unmapped", 32'h0, q);
      test_done;
   end
endmodule : test_parallel_io_ports
